// ===== src/flyback_mode_fault_control.sv
// Purpose: mode selection, switching timing, fault shutdown of a flyback controller
// Assumes: comparator outputs asynchronous, load and feedback given as digital words
// Notes: shutdown holds until supply_low_lockout, which clears it and restarts switching
`timescale 1ns/1ps
module flyback_mode_fault_control #(
   parameter int OCP_LIMIT = flyback_pkg::OCP_CYCLES,
   parameter int TIMER_W = flyback_pkg::TW,
   parameter int RESET_MAX = flyback_pkg::RESET_MAX_CYC,
   parameter int ON_MAX = flyback_pkg::ON_MAX_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // supply
   input wire logic supply_ready,
   // comparators
   input wire flyback_pkg::cmp_t cmp_async,
   // digital measures
   input wire logic [7:0] load_level,
   input wire logic [7:0] peak_current_level,
   input wire logic [9:0] feedback_raw,
   input wire logic [7:0] cable_comp_nom,
   input wire logic [7:0] vout_nom_dv,
   input wire logic [TIMER_W-1:0] on_time_req,
   // drive and status
   output logic base_drive,
   output logic [7:0] base_current_ma,
   output logic [9:0] feedback_comp,
   output flyback_pkg::mode_t mode,
   output logic shutdown,
   output flyback_pkg::fault_t fault_cause
);
   // ************************************************************
   // parameter checks
   // ************************************************************
   if (OCP_LIMIT < 1 || OCP_LIMIT > 255 || RESET_MAX >= (1 << TIMER_W) ||
       ON_MAX >= (1 << TIMER_W) || flyback_pkg::DEEP_PERIOD_CYC >= (1 << TIMER_W))
   begin : g_bad
      $error("flyback parameters out of range");
   end
   // ************************************************************
   // synchronisers
   // ************************************************************
   flyback_pkg::cmp_t sync1_ff;
   flyback_pkg::cmp_t sync_ff;
   flyback_pkg::cmp_t sync_d_ff;
   logic ready1_ff;
   logic ready_ff;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_ff <= '0;
         sync_ff <= '0;
         sync_d_ff <= '0;
         ready1_ff <= 1'b0;
         ready_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= cmp_async;
         sync_ff <= sync1_ff;
         sync_d_ff <= sync_ff;
         ready1_ff <= supply_ready;
         ready_ff <= ready1_ff;
      end
   end
   wire aux_fall_edge = ~sync_ff.aux_fall & sync_d_ff.aux_fall;
   wire valley_edge = sync_ff.valley & ~sync_d_ff.valley;
   wire oc_now = sync_ff.overcurrent_trip;
   // ************************************************************
   // mode selection
   // ************************************************************
   flyback_pkg::mode_t nxt_mode;
   logic run;
   assign run = ready_ff & ~shutdown & ~sync_ff.supply_low_lockout;
   always_comb
   begin
      if (!run)
         nxt_mode = flyback_pkg::MODE_OFF;
      else if (load_level == 8'hff)
         nxt_mode = flyback_pkg::MODE_CURRENT;
      else if (load_level >= flyback_pkg::LOAD_PWM)
         nxt_mode = flyback_pkg::MODE_PWM;
      else if (load_level >= flyback_pkg::LOAD_PFM)
         nxt_mode = flyback_pkg::MODE_PFM;
      else if (load_level >= flyback_pkg::LOAD_DEEP_WIDTH_MODE)
         nxt_mode = flyback_pkg::MODE_DEEP_W;
      else
         nxt_mode = flyback_pkg::MODE_DEEP_F;
   end
   logic cyc_start;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         mode <= flyback_pkg::MODE_OFF;
      else if (!run || cyc_start)
         mode <= nxt_mode;
   end
   // ************************************************************
   // switching cycle
   // ************************************************************
   flyback_pkg::phase_t phase_ff;
   logic [TIMER_W-1:0] on_cnt_ff;
   logic [TIMER_W-1:0] per_cnt_ff;
   logic [TIMER_W-1:0] off_min;
   logic [TIMER_W-1:0] on_target;
   always_comb
   begin
      off_min = '0;
      on_target = on_time_req;
      case (mode)
         flyback_pkg::MODE_PWM: off_min = TIMER_W'(flyback_pkg::PWM_PERIOD_CYC);
         flyback_pkg::MODE_PFM:
         begin
            on_target = TIMER_W'(ON_MAX / 2);
            off_min = TIMER_W'({~load_level, 5'h00});
         end
         flyback_pkg::MODE_DEEP_W: off_min = TIMER_W'(flyback_pkg::DEEP_PERIOD_CYC);
         flyback_pkg::MODE_DEEP_F: off_min = TIMER_W'({~load_level, 5'h1f});
         flyback_pkg::MODE_CURRENT: on_target = TIMER_W'(ON_MAX / 2);
         default: off_min = '0;
      endcase
   end
   assign cyc_start = (phase_ff == flyback_pkg::PH_VALLEY) && valley_edge &&
                      (per_cnt_ff >= off_min);
   logic on_cap;
   logic oc_in_cycle_ff;
   assign on_cap = (on_cnt_ff >= TIMER_W'(ON_MAX - 1));
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_ff <= flyback_pkg::PH_IDLE;
         on_cnt_ff <= '0;
         per_cnt_ff <= '0;
         base_drive <= 1'b0;
      end
      else if (!run)
      begin
         phase_ff <= flyback_pkg::PH_IDLE;
         base_drive <= 1'b0;
         on_cnt_ff <= '0;
         per_cnt_ff <= '0;
      end
      else
      begin
         per_cnt_ff <= (per_cnt_ff == '1) ? per_cnt_ff : per_cnt_ff + 1'b1;
         case (phase_ff)
            flyback_pkg::PH_IDLE:
            begin
               phase_ff <= flyback_pkg::PH_ON;
               base_drive <= 1'b1;
               on_cnt_ff <= '0;
               per_cnt_ff <= '0;
            end
            flyback_pkg::PH_ON:
            begin
               on_cnt_ff <= on_cnt_ff + 1'b1;
               if (oc_now || on_cap || on_cnt_ff + 1'b1 >= on_target)
               begin
                  base_drive <= 1'b0;
                  phase_ff <= flyback_pkg::PH_RESET;
                  on_cnt_ff <= '0;
               end
            end
            flyback_pkg::PH_RESET:
            begin
               on_cnt_ff <= on_cnt_ff + 1'b1;
               if (aux_fall_edge)
                  phase_ff <= flyback_pkg::PH_VALLEY;
            end
            flyback_pkg::PH_VALLEY:
               if (cyc_start)
               begin
                  phase_ff <= flyback_pkg::PH_ON;
                  base_drive <= 1'b1;
                  on_cnt_ff <= '0;
                  per_cnt_ff <= '0;
               end
            default: phase_ff <= flyback_pkg::PH_IDLE;
         endcase
      end
   end
   // ************************************************************
   // overcurrent run counting
   // ************************************************************
   logic [7:0] oc_run_ff;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         oc_in_cycle_ff <= 1'b0;
         oc_run_ff <= '0;
      end
      else if (!run)
      begin
         oc_in_cycle_ff <= 1'b0;
         oc_run_ff <= '0;
      end
      else if (cyc_start)
      begin
         oc_in_cycle_ff <= 1'b0;
         oc_run_ff <= oc_in_cycle_ff ? oc_run_ff + 1'b1 : 8'h00;
      end
      else if (phase_ff == flyback_pkg::PH_ON && oc_now)
         oc_in_cycle_ff <= 1'b1;
   end
   // ************************************************************
   // fault latch
   // ************************************************************
   logic [7:0] started_ff;
   flyback_pkg::fault_t nxt_fault;
   always_comb
   begin
      nxt_fault = '0;
      nxt_fault.reset_timeout = phase_ff == flyback_pkg::PH_RESET &&
                                on_cnt_ff >= TIMER_W'(RESET_MAX - 1);
      nxt_fault.on_timeout = phase_ff == flyback_pkg::PH_ON && on_cap;
      nxt_fault.overcurrent_run = oc_run_ff >= 8'(OCP_LIMIT);
      nxt_fault.overvoltage = phase_ff == flyback_pkg::PH_RESET &&
                              aux_fall_edge && sync_ff.overvoltage_trip;
      nxt_fault.sense_short = started_ff == 8'(flyback_pkg::SHORT_BLANK_CYC) &&
                              sync_ff.sense_short_trip;
      nxt_fault.vout_low = mode == flyback_pkg::MODE_CURRENT && sync_ff.vout_low;
   end
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         started_ff <= '0;
      else if (!ready_ff || sync_ff.supply_low_lockout)
         started_ff <= '0;
      else if (cyc_start && started_ff != 8'(flyback_pkg::SHORT_BLANK_CYC))
         started_ff <= started_ff + 1'b1;
   end
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         shutdown <= 1'b0;
         fault_cause <= '0;
      end
      else if (sync_ff.supply_low_lockout)
      begin
         shutdown <= 1'b0;
         fault_cause <= '0;
      end
      else if (run && nxt_fault != '0)
      begin
         shutdown <= 1'b1;
         fault_cause <= nxt_fault;
      end
   end
   // ************************************************************
   // base current and cable compensation
   // ************************************************************
   logic [8:0] bsum;
   logic [15:0] comp_scaled;
   logic [23:0] comp_off;
   assign bsum = 9'(flyback_pkg::BASE_MIN_MA) + 9'(peak_current_level[7:3]);
   assign comp_scaled = 16'(cable_comp_nom) * 16'(vout_nom_dv) /
                        16'(flyback_pkg::NOM_VOUT_DV);
   assign comp_off = (24'(comp_scaled) * 24'(load_level)) >> 8;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         base_current_ma <= flyback_pkg::BASE_MIN_MA;
         feedback_comp <= '0;
      end
      else
      begin
         base_current_ma <= (bsum > 9'(flyback_pkg::BASE_MAX_MA)) ?
                            flyback_pkg::BASE_MAX_MA : bsum[7:0];
         feedback_comp <= 10'(feedback_raw + comp_off[9:0]);
      end
   end
   // ************************************************************
   // assertions
   // ************************************************************
   property p_lockout_off;
      @(posedge sys_clk) disable iff (!rstn)
      sync_ff.supply_low_lockout |=> !base_drive;
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("drive after lockout");
   property p_oc_cut;
      @(posedge sys_clk) disable iff (!rstn)
      (phase_ff == flyback_pkg::PH_ON && oc_now && run) |=> !base_drive;
   endproperty
   a_oc_cut: assert property (p_oc_cut) else $error("pulse not ended on overcurrent");
   property p_on_cap;
      @(posedge sys_clk) disable iff (!rstn)
      base_drive |-> on_cnt_ff < TIMER_W'(ON_MAX);
   endproperty
   a_on_cap: assert property (p_on_cap) else $error("on-time over cap");
   property p_shut_hold;
      @(posedge sys_clk) disable iff (!rstn)
      (shutdown && !sync_ff.supply_low_lockout) |=> shutdown;
   endproperty
   a_shut_hold: assert property (p_shut_hold) else $error("shutdown released early");
   property p_turn_on_valley;
      @(posedge sys_clk) disable iff (!rstn)
      ($rose(base_drive) && $past(phase_ff) == flyback_pkg::PH_VALLEY) |->
      $past(valley_edge);
   endproperty
   a_turn_on_valley: assert property (p_turn_on_valley) else $error("turn-on off valley");
   property p_base_range;
      @(posedge sys_clk) disable iff (!rstn)
      base_current_ma >= flyback_pkg::BASE_MIN_MA && base_current_ma <= flyback_pkg::BASE_MAX_MA;
   endproperty
   a_base_range: assert property (p_base_range) else $error("base current out of range");
   property p_ocp_run;
      @(posedge sys_clk) disable iff (!rstn)
      (run && oc_run_ff >= 8'(OCP_LIMIT) && !sync_ff.supply_low_lockout) |=> shutdown;
   endproperty
   a_ocp_run: assert property (p_ocp_run) else $error("overcurrent run not shut down");
   property p_reset_timeout;
      @(posedge sys_clk) disable iff (!rstn)
      (run && nxt_fault.reset_timeout && !sync_ff.supply_low_lockout) |=>
      shutdown && fault_cause.reset_timeout;
   endproperty
   a_reset_timeout: assert property (p_reset_timeout) else $error("reset timeout missed");
   property p_not_ready;
      @(posedge sys_clk) disable iff (!rstn)
      !ready_ff |=> !base_drive;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("drive before supply ready");
endmodule

// ===== src/flyback_pkg.sv
// Purpose: shared constants and types of the flyback mode and fault control core
// Assumes: 25 MHz control clock
// Notes: times are kept in their own units, cycle counts derive from them
package flyback_pkg;
   localparam int CLK_MHZ = 25;
   // ************************************************************
   // timing limits
   // ************************************************************
   localparam int RESET_MAX_NS = 110000;
   localparam int RESET_MAX_CYC = (RESET_MAX_NS * CLK_MHZ) / 1000;
   localparam int ON_MAX_NS = 13800;
   localparam int ON_MAX_CYC = (ON_MAX_NS * CLK_MHZ) / 1000;
   localparam int DEEP_PERIOD_NS = 40000;
   localparam int DEEP_PERIOD_CYC = (DEEP_PERIOD_NS * CLK_MHZ) / 1000;
   localparam int PWM_PERIOD_NS = 13889;
   localparam int PWM_PERIOD_CYC = (PWM_PERIOD_NS * CLK_MHZ) / 1000;
   localparam int OCP_CYCLES = 4;
   localparam int SHORT_BLANK_CYC = 8;
   localparam int TW = 13;
   // ************************************************************
   // drive, cable compensation, load thresholds
   // ************************************************************
   localparam logic [7:0] BASE_MIN_MA = 8'h0d;
   localparam logic [7:0] BASE_MAX_MA = 8'h28;
   localparam logic [7:0] NOM_VOUT_DV = 8'h32;
   localparam logic [7:0] LOAD_PWM = 8'hc0;
   localparam logic [7:0] LOAD_PFM = 8'h60;
   localparam logic [7:0] LOAD_DEEP_WIDTH_MODE = 8'h20;
   localparam logic [7:0] LOAD_DEEP_FREQUENCY_MODE = 8'h08;
   typedef enum logic [5:0] {
      MODE_CURRENT = 6'h01,
      MODE_PWM = 6'h02,
      MODE_PFM = 6'h04,
      MODE_DEEP_W = 6'h08,
      MODE_DEEP_F = 6'h10,
      MODE_OFF = 6'h20
   } mode_t;
   typedef enum logic [3:0] {
      PH_IDLE = 4'h1,
      PH_ON = 4'h2,
      PH_RESET = 4'h4,
      PH_VALLEY = 4'h8
   } phase_t;
   typedef struct packed {
      logic overcurrent_trip;
      logic overvoltage_trip;
      logic supply_low_lockout;
      logic aux_fall;
      logic valley;
      logic sense_short_trip;
      logic vout_low;
   } cmp_t;
   typedef struct packed {
      logic reset_timeout;
      logic on_timeout;
      logic overcurrent_run;
      logic overvoltage;
      logic sense_short;
      logic vout_low;
   } fault_t;
endpackage

// ===== testbench/flyback_switch_model.sv
// Purpose: far side model, bipolar switch with transformer sense windings
// Assumes: outputs change at the falling clock edge
// Notes: aux sense stays high while demagnetising, valleys ring every 8 cycles
`timescale 1ns/1ps
module flyback_switch_model (
   // clock
   input wire logic sys_clk,
   // drive from the core
   input wire logic base_drive,
   // behaviour chosen by the bench
   input wire logic hold_aux,
   input wire logic [7:0] demag_cyc,
   input wire logic [7:0] trip_at,
   // sense outputs
   output logic aux_fall = 1'b0,
   output logic valley = 1'b0,
   output logic trip = 1'b0
);
   int on_cnt = 0;
   int off_cnt = 0;
   always @(negedge sys_clk)
   begin
      if (base_drive)
      begin
         off_cnt = 0;
         on_cnt = on_cnt + 1;
         aux_fall <= 1'b0;
         valley <= 1'b0;
         trip <= (trip_at != 8'h00) && (on_cnt >= int'(trip_at));
      end
      else
      begin
         on_cnt = 0;
         off_cnt = off_cnt + 1;
         trip <= 1'b0;
         aux_fall <= hold_aux || (off_cnt <= int'(demag_cyc));
         valley <= !hold_aux && (off_cnt > int'(demag_cyc) + 3) && ((off_cnt % 8) < 3);
      end
   end
endmodule

// ===== testbench/flyback_mode_fault_control_test.sv
// Purpose: self-checking bench of the flyback mode and fault control core
// Assumes: shortened reset and on-time limits
// Notes: shutdowns are compared against a queue of provoked faults
`timescale 1ns/1ps
module flyback_mode_fault_control_test;
   localparam int RMAX = 40;
   localparam int OMAX = 20;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic supply_ready = 1'b0;
   logic ov = 1'b0, lock = 1'b0, sshort = 1'b0, vlow = 1'b0, hold_aux = 1'b0;
   logic vflag = 1'b1, bd_d = 1'b0;
   logic [7:0] demag = 8'h0c, trip_at = 8'h00, load = 8'he0, pk = 8'h00;
   logic [7:0] ccomp = 8'h00, vnom = 8'h32;
   logic [9:0] fb_raw = 10'h000;
   logic [flyback_pkg::TW-1:0] on_req = 13'h000a;
   logic base_drive, m_fall, m_valley, m_trip, shutdown;
   logic [7:0] base_ma;
   logic [9:0] fb_comp, c1, c2;
   flyback_pkg::mode_t mode;
   flyback_pkg::fault_t cause;
   flyback_pkg::cmp_t cmp;
   flyback_pkg::fault_t exp_q[$];
   int miscompares = 0, compares = 0, cycles = 0, pulses = 0, w, p1, p2;
   logic [7:0] load_tab [5] = '{8'hff, 8'he0, 8'h80, 8'h30, 8'h02};
   flyback_pkg::mode_t mode_tab [5] = '{flyback_pkg::MODE_CURRENT, flyback_pkg::MODE_PWM,
      flyback_pkg::MODE_PFM, flyback_pkg::MODE_DEEP_W, flyback_pkg::MODE_DEEP_F};
   // ************************************************************
   // clock, comparators, instances
   // ************************************************************
   always #20 sys_clk = ~sys_clk;
   always_comb
   begin
      cmp = '0;
      cmp.overcurrent_trip = m_trip;
      cmp.overvoltage_trip = ov;
      cmp.supply_low_lockout = lock;
      cmp.aux_fall = m_fall;
      cmp.valley = m_valley;
      cmp.sense_short_trip = sshort;
      cmp.vout_low = vlow;
   end
   flyback_switch_model i_model (.sys_clk(sys_clk), .base_drive(base_drive),
      .hold_aux(hold_aux), .demag_cyc(demag), .trip_at(trip_at), .aux_fall(m_fall),
      .valley(m_valley), .trip(m_trip));
   flyback_mode_fault_control #(.RESET_MAX(RMAX), .ON_MAX(OMAX)) i_dut (.sys_clk(sys_clk),
      .rstn(rstn), .supply_ready(supply_ready), .cmp_async(cmp), .load_level(load),
      .peak_current_level(pk), .feedback_raw(fb_raw), .cable_comp_nom(ccomp),
      .vout_nom_dv(vnom), .on_time_req(on_req), .base_drive(base_drive),
      .base_current_ma(base_ma), .feedback_comp(fb_comp), .mode(mode),
      .shutdown(shutdown), .fault_cause(cause));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_ok(input logic c);
      check({15'h0000, c}, 16'h0001);
   endtask
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic period(output int p);
      int t0;
      @(posedge base_drive);
      t0 = cycles;
      @(posedge base_drive);
      p = cycles - t0;
      @(negedge sys_clk);
   endtask
   task automatic pulse_w(output int p);
      int t0;
      @(posedge base_drive);
      t0 = cycles;
      @(negedge base_drive);
      p = cycles - t0;
      @(negedge sys_clk);
   endtask
   task automatic restart;
      lock = 1'b1;
      wait_cyc(6);
      check_ok(base_drive === 1'b0);
      check_ok(shutdown === 1'b0);
      lock = 1'b0;
   endtask
   task automatic recover;
      int p;
      ov = 1'b0;
      sshort = 1'b0;
      vlow = 1'b0;
      hold_aux = 1'b0;
      trip_at = 8'h00;
      on_req = 13'h000a;
      restart();
      wait_cyc(20);
      p = pulses;
      wait_cyc(400);
      check_ok(pulses > p);
   endtask
   task automatic fault(input logic [5:0] f);
      int p;
      exp_q.push_back(flyback_pkg::fault_t'(f));
      for (int i = 0; i < 3000 && !shutdown; i++) @(negedge sys_clk);
      wait_cyc(2);
      p = pulses;
      wait_cyc(100);
      check(16'(pulses - p), 16'h0000);
   endtask
   // ************************************************************
   // monitors
   // ************************************************************
   always @(posedge shutdown)
   begin
      #1;
      if (exp_q.size() == 0)
         check(16'(cause), 16'hffff);
      else
         check(16'(cause), 16'(exp_q.pop_front()));
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles > 70000)
      begin
         miscompares++;
         complete_run();
      end
      if (base_drive && !bd_d)
      begin
         pulses++;
         check_ok(vflag);
         vflag = 1'b0;
      end
      if (m_valley || shutdown || lock || !supply_ready)
         vflag = 1'b1;
      bd_d = base_drive;
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      void'($urandom(32'h2e2f));
      wait_cyc(4);
      check(16'(mode), 16'(flyback_pkg::MODE_OFF));
      check({8'h00, base_ma}, 16'h000d);
      check({6'h00, fb_comp}, 16'h0000);
      rstn = 1'b1;
      wait_cyc(50);
      check(16'(pulses), 16'h0000);
      supply_ready = 1'b1;
      foreach (load_tab[i])
      begin
         load = load_tab[i];
         on_req = 13'(6 + $urandom % 10);
         pk = 8'($urandom);
         fb_raw = 10'($urandom);
         demag = 8'(6 + $urandom % 15);
         for (int k = 0; k < 7000 && mode !== mode_tab[i]; k++) @(negedge sys_clk);
         check(16'(mode), 16'(mode_tab[i]));
         check({6'h00, fb_comp}, {6'h00, fb_raw});
      end
      load = 8'he0;
      wait_cyc(1500);
      period(w);
      check_ok(w >= flyback_pkg::PWM_PERIOD_CYC && w <= flyback_pkg::PWM_PERIOD_CYC + 40);
      load = 8'h30;
      wait_cyc(1500);
      period(w);
      check_ok(w >= flyback_pkg::DEEP_PERIOD_CYC && w <= flyback_pkg::DEEP_PERIOD_CYC + 40);
      load = 8'hb0;
      wait_cyc(1500);
      period(p1);
      load = 8'h70;
      wait_cyc(1500);
      period(p2);
      check_ok(p2 > p1);
      load = 8'he0;
      pk = 8'h00;
      wait_cyc(1000);
      check({8'h00, base_ma}, 16'h000d);
      pk = 8'hff;
      wait_cyc(1000);
      check({8'h00, base_ma}, 16'h0028);
      fb_raw = 10'h0c8;
      ccomp = 8'h14;
      wait_cyc(1000);
      c1 = fb_comp;
      vnom = 8'h64;
      wait_cyc(1000);
      c2 = fb_comp;
      check_ok(c1 > 10'h0c8 && c2 > c1);
      ccomp = 8'h00;
      on_req = 13'h000f;
      trip_at = 8'h05;
      pulse_w(w);
      trip_at = 8'h00;
      check_ok(w <= 10);
      pulse_w(w);
      check_ok(w >= 14);
      trip_at = 8'h03;
      fault(6'h08);
      recover();
      on_req = 13'(OMAX + 5);
      fault(6'h10);
      recover();
      @(posedge base_drive);
      @(negedge sys_clk);
      hold_aux = 1'b1;
      fault(6'h20);
      recover();
      ov = 1'b1;
      fault(6'h04);
      recover();
      sshort = 1'b1;
      restart();
      fault(6'h02);
      restart();
      fault(6'h02);
      recover();
      load = 8'hff;
      vlow = 1'b1;
      fault(6'h01);
      recover();
      wait_cyc(50);
      check(16'(exp_q.size()), 16'h0000);
      complete_run();
   end
endmodule
